// ---- rtl/frevs_bank.sv ----
// receive framer event status bank: errored and alignment event bytes
// assumes detector pulses synchronous to i_clock, wishbone host
//
// How it works
// RQ1 - errored events latch a one in their bit
// RQ2 - bit 0: coding or excess zeros violation
// RQ3 - bit 1: framing bit or pattern error
// RQ4 - bit 2: crc check failure
// RQ5 - bit 3: excess crc, esf or crc-4 only
// RQ6 - bit 4: e bit zero, frames 13/15
// RQ7 - bit 5: 100/400 ms interworking timer expiry
// RQ8 - bit 6: elastic store overflow slip
// RQ9 - bit 7: elastic store underflow slip
// RQ10 - alignment bit 0: new differing frame alignment
// RQ11 - bit 1: superframe lock, needs frame alignment in sf or cept mode
// RQ12 - ds1 bit 2: loop release code seen
// RQ13 - cept bit 2: transmit biframe alignment found
// RQ14 - ds1 bit 3: loop activate code seen
// RQ15 - cept bit 3: crc-4 multiframe alignment found
// RQ16 - bits hold until read; recurring ones survive; a mode write that masks bits 3-5 clears them without a read
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module frevs_bank #(
    parameter int T100_CYC = frevs_pkg::T100_CYC,
    parameter int T400_CYC = frevs_pkg::T400_CYC
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    // wishbone
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [13:0]       i_wb_adr,
    input  wire logic [3:0]        i_wb_sel,
    input  wire logic [31:0]       i_wb_dat,
    output logic      [31:0]       o_wb_dat,
    output logic                   o_wb_ack,
    // framer detectors
    input  wire frevs_pkg::frevs_evt_t i_evt,
    // interrupt
    output logic                   o_irq
);
    localparam int TW = frevs_pkg::TMR_W;
    localparam logic [TW-1:0] T100_END = TW'(T100_CYC - 1);
    localparam logic [TW-1:0] T400_END = TW'(T400_CYC - 1);

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    frevs_pkg::frevs_acc_t acc;
    logic [31:0]           rdata;

    frevs_wb_slave u_bus (
        .i_clock  (i_clock),
        .i_nrst   (i_nrst),
        .i_wb_cyc (i_wb_cyc),
        .i_wb_stb (i_wb_stb),
        .i_wb_we  (i_wb_we),
        .i_wb_adr (i_wb_adr),
        .i_wb_sel (i_wb_sel),
        .i_wb_dat (i_wb_dat),
        .o_wb_dat (o_wb_dat),
        .o_wb_ack (o_wb_ack),
        .i_rdata  (rdata),
        .o_acc    (acc)
    );

    logic rd_err;
    logic rd_aln;
    logic wr_mode;
    logic wr_iclr;
    logic wr_ien;
    assign rd_err  = acc.take && !acc.we && acc.idx == frevs_pkg::IDX_ERR;
    assign rd_aln  = acc.take && !acc.we && acc.idx == frevs_pkg::IDX_ALN;
    assign wr_mode = acc.take && acc.we && acc.idx == frevs_pkg::IDX_MODE;
    assign wr_iclr = acc.take && acc.we && acc.idx == frevs_pkg::IDX_ICLR;
    assign wr_ien  = acc.take && acc.we && acc.idx == frevs_pkg::IDX_IEN;

    // ------------------------------------------------------------
    // line mode
    // ------------------------------------------------------------
    frevs_pkg::frevs_mode_t mode_d;
    frevs_pkg::frevs_mode_t mode_q;
    logic                   is_cept;
    logic                   ece_ok;
    logic                   need_fa;

    always_comb begin
        mode_d = (wr_mode && acc.sel[0]) ? frevs_pkg::frevs_mode_t'(acc.wdat[3:0]) : mode_q;
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            mode_q <= frevs_pkg::MODE_RST;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign is_cept = mode_q.cept;
    assign ece_ok  = frevs_pkg::ece_valid(mode_q);
    // superframe and cept search only runs inside frame alignment
    assign need_fa = mode_q.sf || mode_q.cept;

    // ------------------------------------------------------------
    // frame alignment history
    // ------------------------------------------------------------
    logic [7:0] prev_pos_d;
    logic [7:0] prev_pos_q;
    logic       have_prev_d;
    logic       have_prev_q;
    logic       new_align;

    always_comb begin
        prev_pos_d  = i_evt.align_found ? i_evt.align_pos : prev_pos_q;
        have_prev_d = have_prev_q || i_evt.align_found;
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            prev_pos_q  <= 8'h00;
            have_prev_q <= 1'b0;
        end else begin
            prev_pos_q  <= prev_pos_d;
            have_prev_q <= have_prev_d;
        end
    end

    // the very first alignment has nothing to differ from
    assign new_align = i_evt.align_found && have_prev_q &&
                       i_evt.align_pos != prev_pos_q; // RQ10

    // ------------------------------------------------------------
    // crc-4 interworking timer
    // ------------------------------------------------------------
    frevs_pkg::frevs_tm_t tm_d;
    frevs_pkg::frevs_tm_t tm_q;
    logic [TW-1:0]        tm_cnt_d;
    logic [TW-1:0]        tm_cnt_q;
    logic                 basic_q;
    logic                 tm_ok;
    logic                 tm_exp;

    assign tm_ok = is_cept && mode_q.crc4 && i_evt.basic_aligned &&
                   !i_evt.crc_mf_lock;

    // runs only from the first basic alignment until multiframe lock
    always_comb begin
        tm_d     = tm_q;
        tm_cnt_d = tm_cnt_q;
        tm_exp   = 1'b0;
        case (tm_q)
            frevs_pkg::TM_IDLE: begin
                tm_cnt_d = '0;
                if (tm_ok && !basic_q) begin
                    tm_d = frevs_pkg::TM_RUN;
                end
            end
            frevs_pkg::TM_RUN: begin
                tm_cnt_d = tm_cnt_q + 1'b1;
                if (!tm_ok) begin
                    tm_d = frevs_pkg::TM_IDLE;
                end else if (tm_cnt_q == T400_END) begin
                    tm_exp = 1'b1; // RQ7
                    tm_d   = frevs_pkg::TM_DONE;
                end else if (tm_cnt_q == T100_END) begin
                    tm_exp = 1'b1; // RQ7
                end
            end
            frevs_pkg::TM_DONE: begin
                if (!i_evt.basic_aligned || !is_cept) begin
                    tm_d = frevs_pkg::TM_IDLE;
                end
            end
            default: begin
                tm_d = frevs_pkg::TM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            tm_q     <= frevs_pkg::TM_IDLE;
            tm_cnt_q <= '0;
            basic_q  <= 1'b0;
        end else begin
            tm_q     <= tm_d;
            tm_cnt_q <= tm_cnt_d;
            basic_q  <= i_evt.basic_aligned;
        end
    end

    // ------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------
    logic [7:0] err_set;
    logic [7:0] err_mask;
    logic [7:0] aln_set;
    logic [7:0] aln_mask;
    logic       ebit_hit;

    assign ebit_hit = i_evt.ebit_valid && !i_evt.ebit_value &&
                      (i_evt.mf_frame == frevs_pkg::EFRM_A ||
                       i_evt.mf_frame == frevs_pkg::EFRM_B);

    always_comb begin
        err_set = 8'h00;
        err_set[frevs_pkg::ERR_LFV]  = i_evt.line_viol;     // RQ2
        err_set[frevs_pkg::ERR_FBE]  = i_evt.frame_bit_err; // RQ3
        err_set[frevs_pkg::ERR_CRC]  = i_evt.crc_fail;      // RQ4
        err_set[frevs_pkg::ERR_ECE]  = i_evt.excess_crc && ece_ok; // RQ5
        err_set[frevs_pkg::ERR_EBIT] = ebit_hit && is_cept; // RQ6
        err_set[frevs_pkg::ERR_TMR]  = tm_exp;              // RQ7
        err_set[frevs_pkg::ERR_SLO]  = i_evt.slip_over;     // RQ8
        err_set[frevs_pkg::ERR_SLU]  = i_evt.slip_under;    // RQ9
        // bits without meaning in the current mode read zero
        err_mask = 8'hFF;
        err_mask[frevs_pkg::ERR_ECE]  = ece_ok;  // RQ5
        err_mask[frevs_pkg::ERR_EBIT] = is_cept; // RQ6
        err_mask[frevs_pkg::ERR_TMR]  = is_cept; // RQ7
    end

    always_comb begin
        aln_set = 8'h00;
        aln_set[frevs_pkg::ALN_NEW] = new_align; // RQ10
        aln_set[frevs_pkg::ALN_SSF] = i_evt.ssf_found &&
            (!need_fa || i_evt.frame_aligned);   // RQ11
        if (is_cept) begin
            aln_set[frevs_pkg::ALN_REL] = i_evt.biframe_lock; // RQ13
            aln_set[frevs_pkg::ALN_ACT] = i_evt.crc_mf_lock;  // RQ15
        end else begin
            aln_set[frevs_pkg::ALN_REL] = i_evt.loop_release;  // RQ12
            aln_set[frevs_pkg::ALN_ACT] = i_evt.loop_activate; // RQ14
        end
        aln_mask = 8'h0F;
    end

    // ------------------------------------------------------------
    // event registers, cleared by a read
    // ------------------------------------------------------------
    logic [7:0] err_q;
    logic [7:0] aln_q;

    frevs_event_latch u_err ( // RQ1
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_set   (err_set),
        .i_mask  (err_mask),
        .i_clr   (rd_err), // RQ16
        .o_q     (err_q)
    );

    frevs_event_latch u_aln (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_set   (aln_set),
        .i_mask  (aln_mask),
        .i_clr   (rd_aln), // RQ16
        .o_q     (aln_q)
    );

    // ------------------------------------------------------------
    // interrupt status, clear and enable
    // ------------------------------------------------------------
    logic [15:0] ist_d;
    logic [15:0] ist_q;
    logic [15:0] ien_d;
    logic [15:0] ien_q;
    logic [15:0] iclr;

    always_comb begin
        iclr  = wr_iclr ? frevs_pkg::be16(16'h0000, acc.wdat, acc.sel)
                        : 16'h0000;
        // a new event beats a clear in the same cycle
        ist_d = (ist_q & ~iclr) | {aln_set, err_set};
        ien_d = wr_ien ? frevs_pkg::be16(ien_q, acc.wdat, acc.sel) : ien_q;
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            ist_q <= 16'h0000;
            ien_q <= frevs_pkg::IEN_RST;
        end else begin
            ist_q <= ist_d;
            ien_q <= ien_d;
        end
    end

    assign o_irq = |(ist_q & ien_q);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata = 32'h00000000;
        if (acc.idx == frevs_pkg::IDX_ERR) begin
            rdata[7:0] = err_q;
        end else if (acc.idx == frevs_pkg::IDX_ALN) begin
            rdata[7:0] = aln_q;
        end else if (acc.idx == frevs_pkg::IDX_MODE) begin
            rdata[3:0] = mode_q;
        end else if (acc.idx == frevs_pkg::IDX_ISTAT) begin
            rdata[15:0] = ist_q;
        end else if (acc.idx == frevs_pkg::IDX_IEN) begin
            rdata[15:0] = ien_q;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_lfv_latch: assert property ( // RQ2
        i_evt.line_viol |=> err_q[0] [*2] or (err_q[0] ##1 $past(rd_err)))
        else $error("line violation not latched");
    a_fbe_latch: assert property (i_evt.frame_bit_err |=> err_q[1]) // RQ3
        else $error("framing bit error not latched");
    a_crc_latch: assert property ( // RQ4
        i_evt.crc_fail && !rd_err |=> err_q[2] ##1 (err_q[2] || $past(rd_err)))
        else $error("crc failure not latched");
    a_ece_gated: assert property (!ece_ok |=> !err_q[3]) // RQ5
        else $error("excess crc shown in wrong mode");
    a_ebit_frame: assert property ( // RQ6
        is_cept && i_evt.ebit_valid && !i_evt.ebit_value &&
        i_evt.mf_frame == 4'hD |=> err_q[4])
        else $error("e bit zero missed");
    a_ebit_ds1: assert property (!is_cept |=> !err_q[4] && !err_q[5]) // RQ6
        else $error("cept-only bit set in ds1");
    a_tmr_end: assert property ( // RQ7
        tm_q == frevs_pkg::TM_RUN && tm_cnt_q == T400_END && tm_ok
        |=> tm_q == frevs_pkg::TM_DONE && err_q[5])
        else $error("interworking timer expiry lost");
    a_slip_over: assert property (i_evt.slip_over |=> err_q[6]) // RQ8
        else $error("overflow slip not latched");
    a_slip_under: assert property (i_evt.slip_under |=> err_q[7]) // RQ9
        else $error("underflow slip not latched");
    a_nfa_diff: assert property ( // RQ10
        i_evt.align_found && have_prev_q &&
        i_evt.align_pos != prev_pos_q |=> aln_q[0])
        else $error("new alignment not flagged");
    a_ssf_gate: assert property ( // RQ11
        need_fa && !i_evt.frame_aligned && !aln_q[1] |=> !aln_q[1])
        else $error("superframe lock without frame alignment");
    a_loop_rel: assert property (!is_cept && i_evt.loop_release |=> aln_q[2]) // RQ12
        else $error("loop release code missed");
    a_bfa_cept: assert property (is_cept && i_evt.biframe_lock |=> aln_q[2]) // RQ13
        else $error("biframe lock missed");
    a_loop_act: assert property (!is_cept && i_evt.loop_activate |=> aln_q[3]) // RQ14
        else $error("loop activate code missed");
    a_cma_cept: assert property (is_cept && i_evt.crc_mf_lock |=> aln_q[3]) // RQ15
        else $error("multiframe lock missed");
    a_hold_unread: assert property (err_q[7] && !rd_err |=> err_q[7]) // RQ16
        else $error("event bit dropped without a read");
    a_read_clear: assert property (rd_err && !err_set[7] |=> !err_q[7]) // RQ16
        else $error("read did not clear event bit");
    a_read_keep: assert property ( // RQ16
        rd_aln && aln_set[2] |=> aln_q[2] ##1 (aln_q[2] || $past(rd_aln)))
        else $error("recurring event lost on read");

endmodule
`default_nettype wire

// ---- rtl/frevs_event_latch.sv ----
// sticky event byte, cleared by a read strobe
// assumes set pulses and the clear strobe are synchronous to i_clock
`timescale 1ns/10ps
`default_nettype none
module frevs_event_latch (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    // events
    input  wire logic [7:0] i_set,
    input  wire logic [7:0] i_mask,
    input  wire logic       i_clr,
    // state
    output logic      [7:0] o_q
);
    logic [7:0] q_d;
    logic [7:0] q_q;

    // a set in the clearing cycle survives the read
    always_comb begin
        q_d = ((q_q & ~{8{i_clr}}) | i_set) & i_mask;
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            q_q <= frevs_pkg::EVT_RST;
        end else begin
            q_q <= q_d;
        end
    end

    assign o_q = q_q;
endmodule
`default_nettype wire

// ---- rtl/frevs_pkg.sv ----
// receive framer event status bank: shared constants, types, helpers
// assumes a single 125 MHz clock and a wishbone register port
package frevs_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int          ADR_W     = 14;
    localparam int          IDX_W     = 12;
    localparam logic [11:0] IDX_ERR   = 12'h603;
    localparam logic [11:0] IDX_ALN   = 12'h604;
    localparam logic [11:0] IDX_MODE  = 12'h610;
    localparam logic [11:0] IDX_ISTAT = 12'h611;
    localparam logic [11:0] IDX_ICLR  = 12'h612;
    localparam logic [11:0] IDX_IEN   = 12'h613;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ERR_LFV  = 0;
    localparam int ERR_FBE  = 1;
    localparam int ERR_CRC  = 2;
    localparam int ERR_ECE  = 3;
    localparam int ERR_EBIT = 4;
    localparam int ERR_TMR  = 5;
    localparam int ERR_SLO  = 6;
    localparam int ERR_SLU  = 7;
    localparam int ALN_NEW  = 0;
    localparam int ALN_SSF  = 1;
    localparam int ALN_REL  = 2;
    localparam int ALN_ACT  = 3;

    // ------------------------------------------------------------
    // reset values and frame numbers
    // ------------------------------------------------------------
    localparam logic [3:0]  MODE_RST = 4'h0;
    localparam logic [15:0] IEN_RST  = 16'h0000;
    localparam logic [7:0]  EVT_RST  = 8'h00;
    localparam logic [3:0]  EFRM_A   = 4'hD;
    localparam logic [3:0]  EFRM_B   = 4'hF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ    = 125_000_000;
    localparam int T100_MS   = 100;
    localparam int T400_MS   = 400;
    localparam int T100_CYC  = T100_MS * (CLK_HZ / 1000);
    localparam int T400_CYC  = T400_MS * (CLK_HZ / 1000);
    localparam int TMR_W     = 26;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TM_IDLE = 2'b00,
        TM_RUN  = 2'b01,
        TM_DONE = 2'b10
    } frevs_tm_t;

    typedef struct packed {
        logic sf;
        logic crc4;
        logic esf;
        logic cept;
    } frevs_mode_t;

    typedef struct packed {
        logic        line_viol;
        logic        frame_bit_err;
        logic        crc_fail;
        logic        excess_crc;
        logic        ebit_valid;
        logic        ebit_value;
        logic [3:0]  mf_frame;
        logic        slip_over;
        logic        slip_under;
        logic        frame_aligned;
        logic        basic_aligned;
        logic        align_found;
        logic [7:0]  align_pos;
        logic        ssf_found;
        logic        loop_release;
        logic        loop_activate;
        logic        biframe_lock;
        logic        crc_mf_lock;
    } frevs_evt_t;

    typedef struct packed {
        logic        take;
        logic        we;
        logic [11:0] idx;
        logic [31:0] wdat;
        logic [3:0]  sel;
    } frevs_acc_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic ece_valid(input frevs_mode_t m);
        ece_valid = (m.esf && !m.cept) || (m.cept && m.crc4);
    endfunction

    function automatic logic [15:0] be16(input logic [15:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
        be16 = {sel[1] ? new_v[15:8] : old_v[15:8],
                sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

endpackage

// ---- rtl/frevs_wb_slave.sv ----
// classic wishbone slave front end: one wait state, registered data
// assumes a master that holds its request until it sees ack
`timescale 1ns/10ps
`default_nettype none
module frevs_wb_slave (
    // clock and reset
    input  wire logic                     i_clock,
    input  wire logic                     i_nrst,
    // wishbone
    input  wire logic                     i_wb_cyc,
    input  wire logic                     i_wb_stb,
    input  wire logic                     i_wb_we,
    input  wire logic [13:0]              i_wb_adr,
    input  wire logic [3:0]               i_wb_sel,
    input  wire logic [31:0]              i_wb_dat,
    output logic      [31:0]              o_wb_dat,
    output logic                          o_wb_ack,
    // register side
    input  wire logic [31:0]              i_rdata,
    output frevs_pkg::frevs_acc_t         o_acc
);
    logic        ack_d;
    logic        ack_q;
    logic [31:0] dat_d;
    logic [31:0] dat_q;
    logic        take;

    // ack low after each answer, so a held request is taken once
    assign take = i_wb_cyc && i_wb_stb && !ack_q;

    always_comb begin
        ack_d = take;
        dat_d = (take && !i_wb_we) ? i_rdata : dat_q;
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign o_acc    = '{take: take, we: i_wb_we, idx: i_wb_adr[13:2],
                        wdat: i_wb_dat, sel: i_wb_sel};
    assign o_wb_ack = ack_q;
    assign o_wb_dat = dat_q;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// bench for the event status bank: wishbone tasks and event pulses
// assumes the bank is built with short interworking timer counts
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                  i_clock;
    logic                  i_nrst;
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [13:0]           adr;
    logic [3:0]            sel;
    logic [31:0]           dat;
    logic [31:0]           rdat;
    logic [31:0]           q;
    logic                  ack;
    logic                  irq;
    frevs_pkg::frevs_evt_t evt;
    frevs_pkg::frevs_evt_t base;
    frevs_pkg::frevs_evt_t e;
    int                    n_errors;
    int                    n_tests;

    frevs_bank #(.T100_CYC(10), .T400_CYC(40)) u_frevs_bank (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_evt(evt), .o_irq(irq));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge i_clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 50) chk("wb_ack", 32'h0, 32'h1);
    endtask

    task automatic rc(input string nm, input logic [13:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask

    task automatic pulse(input frevs_pkg::frevs_evt_t p);
        @(posedge i_clock);
        evt <= p;
        @(posedge i_clock);
        evt <= base;
    endtask

    function automatic frevs_pkg::frevs_evt_t mk(input int i, input logic [7:0] p);
        mk = base;
        case (i)
            0: mk.line_viol = 1'b1;
            1: mk.frame_bit_err = 1'b1;
            2: mk.crc_fail = 1'b1;
            3: mk.excess_crc = 1'b1;
            4: begin
                mk.ebit_valid = 1'b1;
                mk.mf_frame = frevs_pkg::EFRM_B;
            end
            6: mk.slip_over = 1'b1;
            7: mk.slip_under = 1'b1;
            10: begin
                mk.align_found = 1'b1;
                mk.align_pos = p;
            end
            11: mk.ssf_found = 1'b1;
            12: mk.loop_release = 1'b1;
            13: mk.loop_activate = 1'b1;
            14: mk.biframe_lock = 1'b1;
            15: mk.crc_mf_lock = 1'b1;
            default: ;
        endcase
    endfunction

    task automatic tally_and_finish;
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        tally_and_finish;
    end

    initial begin
        {cyc, stb, we, adr, sel, dat} = '0;
        evt = '0;
        base = '0;
        i_nrst = 1'b0;
        n_errors = 0;
        n_tests = 0;
        repeat (8) @(posedge i_clock);
        i_nrst <= 1'b1;
        rc("err_rst", 14'h180C, 32'h0);
        rc("aln_rst", 14'h1810, 32'h0);
        rc("unmapped", 14'h1900, 32'h0);
        wb(1'b1, 14'h180C, 32'hFF);
        rc("err_ro", 14'h180C, 32'h0);
        // only bit 2 enabled, so a coding violation must not interrupt
        wb(1'b1, 14'h184C, 32'h4);
        pulse(mk(0, 8'h0));
        repeat (3) @(posedge i_clock);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        pulse(mk(2, 8'h0));
        repeat (3) @(posedge i_clock);
        chk("irq_set", {31'h0, irq}, 32'h1);
        rc("istat", 14'h1844, 32'h5);
        rc("err_irq", 14'h180C, 32'h5);
        chk("irq_hold", {31'h0, irq}, 32'h1);
        wb(1'b1, 14'h1848, 32'h4);
        repeat (2) @(posedge i_clock);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        rc("istat_clr", 14'h1844, 32'h1);
        rc("mode_rst", 14'h1840, 32'h0);
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, 14'h1840, m ? 32'h5 : 32'h0);
            for (int i = 0; i < 8; i++) begin
                pulse(mk(i, 8'h0));
                rc("err_bit", 14'h180C, (i == 5 || (!m && (i == 3 || i == 4))) ? 32'h0
                   : 32'h1 << i);
                rc("err_cor", 14'h180C, 32'h0);
            end
        end
        e = mk(4, 8'h0);
        e.mf_frame = 4'hC;
        pulse(e);
        rc("ebit_f12", 14'h180C, 32'h0);
        e.mf_frame = frevs_pkg::EFRM_A;
        pulse(e);
        rc("ebit_f13", 14'h180C, 32'h10);
        wb(1'b1, 14'h1840, 32'h2);
        pulse(mk(3, 8'h0));
        rc("ece_esf", 14'h180C, 32'h8);
        wb(1'b1, 14'h1840, 32'h0);
        pulse(mk(10, 8'h5));
        pulse(mk(10, 8'h5));
        rc("aln_same", 14'h1810, 32'h0);
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, 14'h1840, m ? 32'h5 : 32'h0);
            for (int i = 10; i < 16; i++) begin
                pulse(mk(i, 8'h6 + 8'(m)));
                rc("aln_bit", 14'h1810, i == 10 ? 32'h1 : (m ? (i > 13 ? 32'h1 << (i - 12)
                   : 32'h0) : (i < 14 ? 32'h1 << (i - 10) : 32'h0)));
            end
        end
        wb(1'b1, 14'h1840, 32'h8);
        pulse(mk(11, 8'h0));
        rc("ssf_sf_gate", 14'h1810, 32'h0);
        wb(1'b1, 14'h1840, 32'h5);
        base.frame_aligned = 1'b1;
        pulse(mk(11, 8'h0));
        rc("ssf_aligned", 14'h1810, 32'h2);
        // a level held across the read must survive the clear
        wb(1'b1, 14'h1840, 32'h0);
        e = mk(0, 8'h0);
        e.loop_release = 1'b1;
        @(posedge i_clock);
        evt <= e;
        rc("recur_a", 14'h180C, 32'h1);
        rc("recur_b", 14'h180C, 32'h1);
        rc("recur_aln", 14'h1810, 32'h4);
        @(posedge i_clock);
        evt <= base;
        rc("recur_c", 14'h180C, 32'h1);
        rc("recur_d", 14'h180C, 32'h0);
        wb(1'b1, 14'h1840, 32'h5);
        base.basic_aligned = 1'b1;
        @(posedge i_clock);
        evt <= base;
        repeat (20) @(posedge i_clock);
        rc("tmr_short", 14'h180C, 32'h20);
        repeat (40) @(posedge i_clock);
        rc("tmr_long", 14'h180C, 32'h20);
        repeat (50) @(posedge i_clock);
        rc("tmr_done", 14'h180C, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
